// ===== rtl/rsqt_top.sv
/*
 * Radio sequencer transition core: next-state choice after receive timeout,
 * packet reception and timer expiry, with its registers and interrupt.
 * Assumes event inputs are one-cycle pulses or levels from logic on REF_CLK.
 */
// Chosen here: the address-and-strobe port.
`default_nettype none
module rsqt_top import rsqt_pkg::*; #(
    parameter int unsigned TICK1_CYC = TICK_64US_CYC,   // 64 us tick
    parameter int unsigned TICK2_CYC = TICK_4MS_CYC,    // 4.1 ms tick
    parameter int unsigned TICK3_CYC = TICK_262MS_CYC   // 262 ms tick
) (
    // Clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       ARST_N,
    // Register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    output logic      [7:0] RD_DATA,
    // Sequencer events
    input  wire logic       SIGNAL_STRENGTH_WAIT_EXPIRED,
    input  wire logic       PREAMBLE_WAIT_EXPIRED,
    input  wire logic       SYNC_WAIT_EXPIRED,
    input  wire logic       PAYLOAD_COMPLETE_FLAG,
    input  wire logic       QUEUE_DRAINED_FLAG,
    input  wire logic       PACKET_SENT,
    input  wire logic       FREQ_CHANGED,
    input  wire logic       SYNTH_READY,
    // Mode requests
    output logic            MODE_RX,
    output logic            MODE_TX,
    output logic            MODE_SYNTH,
    output logic            RECEIVER_RELAUNCH,
    output logic            SEQUENCER_HALTED,
    // Interrupt
    output logic            IRQ
);
    rsqt_state_t  state_r;         // Current sequencer state
    rsqt_state_t  state_nxt;       // Next sequencer state
    rsqt_state_t  lp_target;       // Where low_power_choice leads
    rsqt_state_t  to_target;       // Where a receive timeout leads
    logic [7:0]   seq_cfg2_r;      // sequencer_config_two
    logic [1:0]   tick_sel_r;      // first_timer_tick_select
    logic [7:0]   mult_r;          // first_timer_multiplier
    logic [1:0]   ctrl_r;          // low_power_choice, idle exit to receive
    logic [7:0]   rd_data_r;       // Read data, one cycle after strobe
    logic [2:0]   rx_exit;         // receive_exit_select
    logic [1:0]   rx_to_code;      // rx_timeout_next_state
    logic [2:0]   pkt_code;        // after_rx_packet_next
    logic         start_req;       // Start strobe written
    logic         stop_req;        // Stop strobe written
    logic         receive_timeout_event;
    logic         payload_as_to;   // Payload complete taking the timeout path
    logic         to_taken;        // Timeout transition performed
    logic [IRQ_N-1:0] ev;          // Event pulses to the flags
    logic [IRQ_N-1:0] irq_stat;    // Sticky flags
    logic [IRQ_N-1:0] irq_mask;    // Flag enables
    logic         irq_int;         // Combined interrupt

    rsqt_t1_if t1 ();

    // Field views
    assign rx_exit    = seq_cfg2_r[RX_EXIT_LSB +: 3];
    assign rx_to_code = seq_cfg2_r[RX_TO_LSB +: 2];
    assign pkt_code   = seq_cfg2_r[PKT_LSB +: 3];
    assign start_req  = WR_EN && (ADDR == ADDR_CTRL) && WR_DATA[CTRL_START];
    assign stop_req   = WR_EN && (ADDR == ADDR_CTRL) && WR_DATA[CTRL_STOP];

    // Any wait expiry counts as a receive timeout
    assign receive_timeout_event = SIGNAL_STRENGTH_WAIT_EXPIRED || PREAMBLE_WAIT_EXPIRED
                                   || SYNC_WAIT_EXPIRED;
    // Payload takes the timeout path under exit select 011
    assign payload_as_to = PAYLOAD_COMPLETE_FLAG && (rx_exit == 3'h3);
    assign to_taken      = (state_r == ST_RX) && !stop_req
                           && (receive_timeout_event || payload_as_to);

    // Low-power choice: idle or halt
    assign lp_target = ctrl_r[CTRL_LPC - 2] ? ST_IDLE : ST_OFF;

    // Receive timeout destination
    always_comb begin
        case (rx_to_code)
            2'h0:    to_target = ST_RESTART;
            2'h1:    to_target = ST_TX;
            2'h2:    to_target = lp_target;
            default: to_target = ST_OFF;
        endcase
    end

    // Next-state choice; stop has priority over every event
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                // Events are ignored while halted
                if (start_req && !stop_req) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Timer expiry leaves Idle
                if (t1.expiry) begin
                    state_nxt = ctrl_r[CTRL_IDLERX - 2] ? ST_RX : ST_TX;
                end
            end
            ST_RX: begin
                // Timeout outranks an ordinary payload exit
                if (receive_timeout_event || payload_as_to) begin
                    state_nxt = to_target;
                end else if (PAYLOAD_COMPLETE_FLAG && (rx_exit == 3'h1)) begin
                    state_nxt = ST_PKT;
                end else if (PAYLOAD_COMPLETE_FLAG && (rx_exit == 3'h2)) begin
                    state_nxt = lp_target;
                end
            end
            ST_TX: begin
                if (PACKET_SENT) begin
                    state_nxt = lp_target;
                end
            end
            ST_PKT: begin
                case (pkt_code)
                    3'h0:    state_nxt = ST_OFF;
                    3'h1:    state_nxt = QUEUE_DRAINED_FLAG ? ST_TX : ST_PKT;
                    3'h2:    state_nxt = lp_target;
                    3'h3:    state_nxt = FREQ_CHANGED ? ST_SYNTH : ST_RX;
                    3'h4:    state_nxt = ST_RX;
                    default: state_nxt = ST_OFF;
                endcase
            end
            ST_SYNTH: begin
                // Back to receive once the synthesizer has settled
                if (SYNTH_READY) begin
                    state_nxt = ST_RX;
                end
            end
            ST_RESTART: begin
                // One-cycle relaunch, then receive again
                state_nxt = ST_RX;
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        if (stop_req) begin
            state_nxt = ST_OFF;
        end
    end

    // State register
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Transition configuration register
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            seq_cfg2_r <= RST_SEQ_CFG2;
        end else if (WR_EN && (ADDR == ADDR_SEQ_CFG2)) begin
            seq_cfg2_r <= WR_DATA;
        end
    end

    // Timer configuration registers
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tick_sel_r <= RST_TICK_SEL;
            mult_r     <= RST_MULT;
        end else if (WR_EN && (ADDR == ADDR_TMR_RESOL)) begin
            tick_sel_r <= WR_DATA[TICK_LSB +: 2];
        end else if (WR_EN && (ADDR == ADDR_TMR_MULT)) begin
            mult_r <= WR_DATA;
        end
    end

    // Control options
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_r <= RST_CTRL;
        end else if (WR_EN && (ADDR == ADDR_CTRL)) begin
            ctrl_r <= WR_DATA[CTRL_IDLERX:CTRL_LPC];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_data_r <= 8'h00;
        end else if (RD_EN) begin
            case (ADDR)
                ADDR_SEQ_CFG2:  rd_data_r <= seq_cfg2_r;
                ADDR_TMR_RESOL: rd_data_r <= {4'h0, tick_sel_r, 2'h0};
                ADDR_TMR_MULT:  rd_data_r <= mult_r;
                ADDR_CTRL:      rd_data_r <= {4'h0, ctrl_r, 2'h0};
                ADDR_STATE:     rd_data_r <= {1'b0, state_r};
                ADDR_IRQ_STAT:  rd_data_r <= {4'h0, irq_stat};
                ADDR_IRQ_MASK:  rd_data_r <= {4'h0, irq_mask};
                default:        rd_data_r <= 8'h00;
            endcase
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    // Timer runs only in Idle
    assign t1.tick_sel = tick_sel_r;
    assign t1.mult     = mult_r;
    assign t1.run      = (state_r == ST_IDLE);

    rsqt_timer #(
        .TICK1_CYC (TICK1_CYC),
        .TICK2_CYC (TICK2_CYC),
        .TICK3_CYC (TICK3_CYC)
    ) u_timer (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .t1     (t1.tmr)
    );

    // Event pulses into the sticky flags
    assign ev[EV_TIMER] = t1.expiry;
    assign ev[EV_RXTO]  = to_taken;
    assign ev[EV_HALT]  = (state_nxt == ST_OFF) && (state_r != ST_OFF);
    assign ev[EV_PKT]   = (state_nxt == ST_PKT) && (state_r != ST_PKT);

    rsqt_irq #(
        .N (IRQ_N)
    ) u_irq (
        .clk     (REF_CLK),
        .arst_n  (ARST_N),
        .ev      (ev),
        .clr_we  (WR_EN && (ADDR == ADDR_IRQ_STAT)),
        .mask_we (WR_EN && (ADDR == ADDR_IRQ_MASK)),
        .wdata   (WR_DATA[IRQ_N-1:0]),
        .stat    (irq_stat),
        .mask    (irq_mask),
        .irq     (irq_int)
    );

    // Outputs
    assign RD_DATA           = rd_data_r;
    assign MODE_RX           = (state_r == ST_RX);
    assign MODE_TX           = (state_r == ST_TX);
    assign MODE_SYNTH        = (state_r == ST_SYNTH);
    assign RECEIVER_RELAUNCH = (state_r == ST_RESTART);
    assign SEQUENCER_HALTED  = (state_r == ST_OFF);
    assign IRQ               = irq_int;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    a_timeout_relaunch: assert property (
        (state_r == ST_RX) && !stop_req && receive_timeout_event && (rx_to_code == 2'h0)
        |=> RECEIVER_RELAUNCH ##1 (MODE_RX || SEQUENCER_HALTED))
        else $error("timeout code 00 did not relaunch receive");
    a_timeout_dest: assert property (
        to_taken && (rx_to_code != 2'h0)
        |=> (rx_to_code == 2'h1) ? MODE_TX
          : (rx_to_code == 2'h3) ? SEQUENCER_HALTED
          : (state_r == ($past(ctrl_r[0]) ? ST_IDLE : ST_OFF)))
        else $error("timeout went to wrong state");
    a_payload_timeout: assert property (
        (state_r == ST_RX) && !stop_req && PAYLOAD_COMPLETE_FLAG && (rx_exit == 3'h3)
        && (rx_to_code == 2'h1) |=> MODE_TX)
        else $error("payload under 011 missed timeout path");
    a_wait_timeout: assert property (
        (state_r == ST_RX) && (SYNC_WAIT_EXPIRED || PREAMBLE_WAIT_EXPIRED
        || SIGNAL_STRENGTH_WAIT_EXPIRED) && (rx_to_code == 2'h3) |=> SEQUENCER_HALTED)
        else $error("wait expiry not treated as timeout");
    a_pkt_drained: assert property (
        (state_r == ST_PKT) && !stop_req && (pkt_code == 3'h1)
        |=> $past(QUEUE_DRAINED_FLAG) ? MODE_TX : (state_r == ST_PKT))
        else $error("packet code 001 misbehaved");
    a_pkt_halt: assert property (
        (state_r == ST_PKT) && (pkt_code == 3'h0) |=> SEQUENCER_HALTED)
        else $error("packet code 000 did not halt");
    a_pkt_return: assert property (
        (state_r == ST_PKT) && !stop_req && (pkt_code == 3'h3) && FREQ_CHANGED
        ##1 (MODE_SYNTH && SYNTH_READY && !stop_req) |=> MODE_RX)
        else $error("return via synthesizer failed");
    a_idle_exit: assert property (
        (state_r == ST_IDLE) && !stop_req && t1.expiry
        |=> (state_r == ($past(ctrl_r[1]) ? ST_RX : ST_TX)))
        else $error("timer expiry did not leave idle");
    a_halt_ignores: assert property (
        SEQUENCER_HALTED && !start_req |=> SEQUENCER_HALTED [*1])
        else $error("halted sequencer moved without start");

    c_relaunch:   cover property (RECEIVER_RELAUNCH ##1 MODE_RX);
    c_pkt_to_tx:  cover property ((state_r == ST_PKT) ##1 MODE_TX);
    c_idle_to_rx: cover property ((state_r == ST_IDLE) ##1 MODE_RX);
    c_synth_path: cover property (MODE_SYNTH ##1 MODE_RX);
endmodule : rsqt_top
`default_nettype wire

// ===== rtl/rsqt_pkg.sv
/*
 * Constants, register map and state encoding of the radio sequencer transition block.
 * Assumes a 100 MHz core clock and an 8-bit register port with byte-wide offsets.
 */
//Contract
//- Timeout code 00 relaunches the receiver
//- Timeout codes 01/10/11: transmit, low-power, halt
//- Exit select 011 applies timeout path on payload
//- Any of three wait expiries is timeout
//- Packet taken: 000 halt, 001 drained transmit, 010 low-power
//- Packet taken: 011 via synthesizer, 100 receive
//- Tick select: off, 64us, 4.1ms, 262ms
//- Timer period is tick times multiplier
//- Timer expiry moves Idle to transmit/receive
`default_nettype none
package rsqt_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SEQ_CFG2  = 8'h37;  // Transition selections
    localparam logic [7:0] ADDR_TMR_RESOL = 8'h38;  // Tick selection
    localparam logic [7:0] ADDR_TMR_MULT  = 8'h39;  // Timer multiplier
    localparam logic [7:0] ADDR_CTRL      = 8'h40;  // Start, stop, low-power options
    localparam logic [7:0] ADDR_STATE     = 8'h41;  // Current state, read only
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h42;  // Sticky events, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h43;  // Interrupt enables
    // Field positions
    localparam int RX_EXIT_LSB = 5;  // receive_exit_select [7:5]
    localparam int RX_TO_LSB   = 3;  // rx_timeout_next_state [4:3]
    localparam int PKT_LSB     = 0;  // after_rx_packet_next [2:0]
    localparam int TICK_LSB    = 2;  // first_timer_tick_select [3:2]
    localparam int CTRL_START  = 0;  // Start strobe
    localparam int CTRL_STOP   = 1;  // Stop strobe
    localparam int CTRL_LPC    = 2;  // low_power_choice: 1 idle, 0 halt
    localparam int CTRL_IDLERX = 3;  // Idle exit: 1 receive, 0 transmit
    // Reset values
    localparam logic [7:0] RST_SEQ_CFG2 = 8'h00;
    localparam logic [1:0] RST_TICK_SEL = 2'h0;
    localparam logic [7:0] RST_MULT     = 8'hF5;
    localparam logic [1:0] RST_CTRL     = 2'h0;
    localparam logic [3:0] RST_IRQ      = 4'h0;
    // Event bits
    localparam int IRQ_N     = 4;
    localparam int EV_TIMER  = 0;  // first_timer_expiry
    localparam int EV_RXTO   = 1;  // receive_timeout_event taken
    localparam int EV_HALT   = 2;  // Entry into sequencer_halted
    localparam int EV_PKT    = 3;  // Entry into packet_taken_state
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TICK_64US_NS   = 64000;
    localparam int unsigned TICK_4MS_NS    = 4100000;
    localparam int unsigned TICK_262MS_NS  = 262000000;
    localparam int unsigned TICK_64US_CYC  = TICK_64US_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_4MS_CYC   = TICK_4MS_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_262MS_CYC = TICK_262MS_NS / CLK_PERIOD_NS;
    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_OFF     = 7'h01,  // sequencer_halted
        ST_IDLE    = 7'h02,
        ST_RX      = 7'h04,
        ST_TX      = 7'h08,
        ST_PKT     = 7'h10,  // packet_taken_state
        ST_SYNTH   = 7'h20,  // synthesizer_mode
        ST_RESTART = 7'h40   // receiver_relaunch
    } rsqt_state_t;
endpackage : rsqt_pkg
`default_nettype wire

// ===== rtl/rsqt_t1_if.sv
/*
 * Link between the sequencer core and the first interval timer.
 * Assumes both ends share one clock.
 */
`default_nettype none
interface rsqt_t1_if;
    logic [1:0] tick_sel;  // first_timer_tick_select
    logic [7:0] mult;      // first_timer_multiplier
    logic       run;       // Timer counts while high
    logic       expiry;    // first_timer_expiry, one-cycle pulse
    modport ctrl (output tick_sel, output mult, output run, input expiry);
    modport tmr  (input tick_sel, input mult, input run, output expiry);
endinterface : rsqt_t1_if
`default_nettype wire

// ===== rtl/rsqt_timer.sv
/*
 * First interval timer: tick prescaler and multiplier counter.
 * Assumes tick counts fit 25 bits and the controller holds run during a period.
 */
`default_nettype none
module rsqt_timer import rsqt_pkg::*; #(
    parameter int unsigned TICK1_CYC = TICK_64US_CYC,
    parameter int unsigned TICK2_CYC = TICK_4MS_CYC,
    parameter int unsigned TICK3_CYC = TICK_262MS_CYC
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   arst_n,
    // Controller side
    rsqt_t1_if.tmr      t1
);
    logic [24:0] pre_r;     // Cycles within one tick
    logic [24:0] pre_lim;   // Last cycle of a tick
    logic [7:0]  tick_r;    // Ticks within one period
    logic        tick_end;  // Last cycle of a tick
    logic        active;    // Timer enabled and running
    logic        exp_r;     // Expiry pulse

    // Tick length from the selection
    always_comb begin
        case (t1.tick_sel)
            2'h1:    pre_lim = 25'(TICK1_CYC - 1);
            2'h2:    pre_lim = 25'(TICK2_CYC - 1);
            2'h3:    pre_lim = 25'(TICK3_CYC - 1);
            default: pre_lim = 25'h0000000;
        endcase
    end
    assign active   = t1.run && (t1.tick_sel != 2'h0);
    assign tick_end = active && (pre_r == pre_lim);

    // Prescaler restarts whenever the timer is stopped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_r <= 25'h0000000;
        end else if (!active || tick_end) begin
            pre_r <= 25'h0000000;
        end else begin
            pre_r <= pre_r + 25'h0000001;
        end
    end

    // Period is multiplier ticks; a zero multiplier acts as one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_r <= 8'h00;
            exp_r  <= 1'b0;
        end else begin
            exp_r <= 1'b0;
            if (!active) begin
                tick_r <= 8'h00;
            end else if (tick_end) begin
                if (tick_r + 8'h01 >= t1.mult) begin
                    tick_r <= 8'h00;
                    exp_r  <= 1'b1;
                end else begin
                    tick_r <= tick_r + 8'h01;
                end
            end
        end
    end
    assign t1.expiry = exp_r;

    a_expiry_disabled: assert property (@(posedge clk) disable iff (!arst_n)
        (t1.tick_sel == 2'h0) [*2] |-> !t1.expiry)
        else $error("timer expired while disabled");
    a_expiry_period: assert property (@(posedge clk) disable iff (!arst_n)
        t1.expiry |-> $past(tick_end) && ($past(tick_r) + 8'h01 >= $past(t1.mult)))
        else $error("timer expired before multiplier ticks");
endmodule : rsqt_timer
`default_nettype wire

// ===== rtl/rsqt_irq.sv
/*
 * Sticky event flags, mask and interrupt line.
 * Assumes one-cycle event pulses and write strobes from the same clock.
 */
`default_nettype none
module rsqt_irq #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Events and software access
    input  wire logic [N-1:0] ev,
    input  wire logic         clr_we,
    input  wire logic         mask_we,
    input  wire logic [N-1:0] wdata,
    // Results
    output logic      [N-1:0] stat,
    output logic      [N-1:0] mask,
    output logic              irq
);
    // Set wins over a simultaneous clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat <= '0;
        end else begin
            stat <= (stat & ~(clr_we ? wdata : '0)) | ev;
        end
    end
    // Mask register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask <= '0;
        end else if (mask_we) begin
            mask <= wdata;
        end
    end
    assign irq = |(stat & mask);
endmodule : rsqt_irq
`default_nettype wire

// ===== verification/test_radio_sequencer_transitions.sv
/*
 * Self-checking bench for the sequencer transition core: register reset values,
 * transition table, tick selection, halted behaviour and interrupt.
 * Assumes short tick parameters and a 100 MHz clock made here.
 */
`default_nettype none
module test_radio_sequencer_transitions import rsqt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK [4] = '{0, 4, 8, 16};  // Shortened tick lengths
    typedef struct {logic [7:0] cfg; int ev; logic dr; logic fq; logic [7:0] exp;} rsqt_row_t;
    logic       clk = 0, arst_n = 0, we = 0, re = 0;  // Clock, reset, strobes
    logic [7:0] addr = 0, wdata = 0;                   // Register port
    logic [3:0] evt = 0;                               // Three waits and payload
    logic       drn = 0, fq = 0, ps = 0, sr = 0;       // Level inputs
    logic [7:0] rdata;                                 // Read data
    logic       m_rx, m_tx, m_sy, rl, halt, irq;       // Outputs
    int         err_total = 0, check_count = 0, cyc = 0, n;
    rsqt_row_t  rows [14] = '{
        '{8'h08,0,0,0,ST_TX}, '{8'h08,1,0,0,ST_TX}, '{8'h08,2,0,0,ST_TX},
        '{8'h10,0,0,0,ST_OFF}, '{8'h18,1,0,0,ST_OFF}, '{8'h68,3,0,0,ST_TX},
        '{8'h20,3,0,0,ST_OFF}, '{8'h21,3,0,0,ST_PKT}, '{8'h21,3,1,0,ST_TX},
        '{8'h22,3,0,0,ST_OFF}, '{8'h23,3,0,1,ST_SYNTH}, '{8'h23,3,0,0,ST_RX},
        '{8'h24,3,0,0,ST_RX}, '{8'h08,3,0,0,ST_RX}};
    rsqt_top #(.TICK1_CYC(4), .TICK2_CYC(8), .TICK3_CYC(16)) dut_u (
        .REF_CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WR_DATA(wdata), .WR_EN(we),
        .RD_EN(re), .RD_DATA(rdata), .SIGNAL_STRENGTH_WAIT_EXPIRED(evt[0]),
        .PREAMBLE_WAIT_EXPIRED(evt[1]), .SYNC_WAIT_EXPIRED(evt[2]),
        .PAYLOAD_COMPLETE_FLAG(evt[3]), .QUEUE_DRAINED_FLAG(drn), .PACKET_SENT(ps),
        .FREQ_CHANGED(fq), .SYNTH_READY(sr), .MODE_RX(m_rx), .MODE_TX(m_tx),
        .MODE_SYNTH(m_sy), .RECEIVER_RELAUNCH(rl), .SEQUENCER_HALTED(halt), .IRQ(irq));
    // Clock, 10 ns period
    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // Compare one byte
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t byte got %h want %h", $time, got, exp);
        end
    endtask
    // Compare one flag
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // Read, then compare in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a; re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk8(rdata, exp);
    endtask
    // Stop, configure, start toward receive; count cycles until receive
    task automatic go(input logic [7:0] c, input logic [1:0] t, input logic [7:0] m);
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_SEQ_CFG2, c);
        wr(ADDR_TMR_RESOL, {4'h0, t, 2'h0});
        wr(ADDR_TMR_MULT, m);
        wr(ADDR_CTRL, 8'h09);
        n = 0;
        while (m_rx !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    // One-cycle event pulse
    task automatic pulse(input int k);
        @(posedge clk);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt <= '0;
    endtask
    // Verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        chk1(halt, 1'b1);
        rd(ADDR_SEQ_CFG2, 8'h00);
        rd(ADDR_TMR_RESOL, 8'h00);
        rd(ADDR_TMR_MULT, 8'hF5);
        rd(ADDR_STATE, ST_OFF);
        rd(8'h50, 8'h00);
        wr(ADDR_TMR_RESOL, 8'hFF);
        rd(ADDR_TMR_RESOL, 8'h0C);
        $display("registers done");
        // Transition table rows
        foreach (rows[i]) begin
            go(rows[i].cfg, 2'h1, 8'h01);
            drn <= rows[i].dr; fq <= rows[i].fq;
            pulse(rows[i].ev);
            repeat (3) @(posedge clk);
            rd(ADDR_STATE, rows[i].exp);
        end
        drn <= 0; fq <= 0;
        $display("table done");
        // Relaunch lasts one cycle, then receive
        go(8'h00, 2'h1, 8'h01);
        pulse(0);
        #1 chk1(rl, 1'b1);
        @(posedge clk);
        #1 chk1(m_rx, 1'b1);
        chk1(rl, 1'b0);
        $display("relaunch done");
        // Synthesizer return, low-power idle choice, idle to transmit, transmit exit
        wr(ADDR_SEQ_CFG2, 8'h23);
        fq <= 1'b1;
        pulse(3);
        @(posedge clk);
        sr <= 1'b1;
        #1 chk1(m_sy, 1'b1);
        @(posedge clk);
        sr <= 1'b0;
        fq <= 1'b0;
        #1 chk1(m_rx, 1'b1);
        wr(ADDR_SEQ_CFG2, 8'h10);
        wr(ADDR_CTRL, 8'h04);
        rd(ADDR_CTRL, 8'h04);
        pulse(2);
        rd(ADDR_STATE, ST_IDLE);
        repeat (3) @(posedge clk);
        #1 chk1(m_tx, 1'b1);
        @(posedge clk);
        ps <= 1'b1;
        @(posedge clk);
        ps <= 1'b0;
        #1 chk1(m_tx, 1'b0);
        chk1(halt, 1'b0);
        $display("modes done");
        // Idle exit time follows tick times multiplier
        for (int t = 1; t < 4; t++) begin
            go(8'h08, t[1:0], 8'h02);
            chk1(n >= 2 * TK[t] && n <= 2 * TK[t] + 4, 1'b1);
        end
        go(8'h08, 2'h0, 8'h01);
        chk1(m_rx, 1'b0);
        $display("timer done");
        // Halted sequencer ignores events
        wr(ADDR_CTRL, 8'h02);
        pulse(1);
        pulse(3);
        rd(ADDR_STATE, ST_OFF);
        chk1(halt, 1'b1);
        $display("halted done");
        // Interrupt raise, mask, clear
        go(8'h08, 2'h1, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h0F);
        wr(ADDR_IRQ_MASK, 8'h04);
        #1 chk1(irq, 1'b0);
        wr(ADDR_CTRL, 8'h02);
        repeat (2) @(posedge clk);
        #1 chk1(irq, 1'b1);
        rd(ADDR_IRQ_STAT, 8'h04);
        wr(ADDR_IRQ_MASK, 8'h00);
        #1 chk1(irq, 1'b0);
        wr(ADDR_IRQ_STAT, 8'h04);
        rd(ADDR_IRQ_STAT, 8'h00);
        $display("interrupt done");
        // Reset in mid-run while receiving
        go(8'h2B, 2'h2, 8'h07);
        arst_n <= 1'b0;
        @(posedge clk);
        #1 chk1(halt, 1'b1);
        chk1(m_rx, 1'b0);
        @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_SEQ_CFG2, 8'h00);
        rd(ADDR_TMR_RESOL, 8'h00);
        rd(ADDR_TMR_MULT, 8'hF5);
        rd(ADDR_STATE, ST_OFF);
        $display("reset done");
        tally_and_finish();
    end
endmodule // test_radio_sequencer_transitions
`default_nettype wire
